// file: design/adc_power_mode_sequencer.v
// Power-mode sequencer of the dual-converter ADC with an AXI4-Lite slave.
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "adc_pwr_regs.vh"
module adc_power_mode_sequencer (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [11:0] s_axi_araddr,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  input  wire        osc_tick,
  input  wire        conv_sync_a,
  input  wire        conv_sync_b,
  input  wire        core_data_valid,
  input  wire [15:0] core_data,
  output reg         adc_clk_en,
  output reg         adc_clk_sel_stby,
  output reg         conv_a_power_en,
  output reg         conv_b_power_en,
  output reg         low_current_en,
  output reg         vref_power_en,
  output reg         vref_out_enable,
  output reg         pwm_data_en,
  output reg         scan_a_active,
  output reg         scan_b_active,
  output reg         result_valid,
  output reg  [15:0] result_data,
  output reg         result_from_cpu
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg  [6:0]  pwr_bits_r;
  reg  [`DELAY_W-1:0] startup_delay_count_r;
  reg  [1:0]  halt_r;
  reg  [5:0]  need_a_r;
  reg  [5:0]  need_b_r;
  reg  [1:0]  done_r;
  reg  [1:0]  psts_r;
  reg  [`DELAY_W-1:0] dly_cnt_r;
  reg         dly_run_r;
  reg         active_d_r;
  reg  [15:0] result_r;
  reg         aw_hold_r;
  reg         w_hold_r;
  reg  [11:0] awaddr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg  [1:0]  scan_r;
  reg  [1:0]  len_a_r;
  reg  [1:0]  len_b_r;
  wire        stby_tick;

  wire conv_a_power_off = pwr_bits_r[`BIT_CONV_A_OFF];
  wire conv_b_power_off = pwr_bits_r[`BIT_CONV_B_OFF];
  wire vref_auto_power_off = pwr_bits_r[`BIT_VREF_AUTO];
  wire auto_powerdown_enable = pwr_bits_r[`BIT_APD];
  wire auto_standby_enable = pwr_bits_r[`BIT_ASB];
  wire clk_enable = pwr_bits_r[`BIT_CLK_EN];
  wire stby_cfg = pwr_bits_r[`BIT_STBY_CFG];

  wire any_on = !conv_a_power_off || !conv_b_power_off;
  wire normal_mode = any_on && !auto_powerdown_enable &&
                     !auto_standby_enable && clk_enable;
  wire active = |scan_r;
  wire conv_a_power_status = psts_r[0];
  wire conv_b_power_status = psts_r[1];

  standby_clk_div #(
    .DIV(`STBY_DIV)
  ) u_div (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .osc_tick  (osc_tick),
    .stby_tick (stby_tick)
  );

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  wire wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  wire wr_pwr = wr_go && awaddr_r == `OFS_POWER_CTRL && wstrb_r[0];
  wire wr_scan = wr_go && awaddr_r == `OFS_SCAN_CTRL && wstrb_r[0];
  wire wr_res = wr_go && awaddr_r == `OFS_RESULT_WR && wstrb_r[0];
  wire known = awaddr_r == `OFS_POWER_CTRL || awaddr_r == `OFS_SCAN_CTRL ||
               awaddr_r == `OFS_RESULT_WR;

  // Halt takes effect from the written value in the same cycle.
  wire [1:0] halt_now = wr_scan ?
       {wdata_r[`BIT_HALT_B], wdata_r[`BIT_HALT_A]} : halt_r;
  wire [1:0] launch_req = {
       conv_sync_b || (wr_scan && wdata_r[`BIT_LAUNCH_B]),
       conv_sync_a || (wr_scan && wdata_r[`BIT_LAUNCH_A])};
  wire [1:0] launch_ok = launch_req & ~halt_now & ~scan_r &
       ~psts_r & ~{conv_b_power_off, conv_a_power_off} & {2{clk_enable}};

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 12'h000;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r     <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `RESP_OKAY;
      case (s_axi_araddr)
        `OFS_POWER_CTRL: s_axi_rdata <= {10'h000, startup_delay_count_r,
             4'h0, conv_b_power_status, conv_a_power_status,
             3'h0, pwr_bits_r};
        `OFS_SCAN_CTRL: s_axi_rdata <= {10'h000, need_b_r, 2'h0, need_a_r,
             2'h0, done_r, halt_r, 2'h0};
        `OFS_RESULT_RD: s_axi_rdata <= {16'h0000, result_r};
        `OFS_ACTIVITY: s_axi_rdata <= {28'h0000000, scan_r, psts_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      pwr_bits_r            <= `PWR_RESET;
      startup_delay_count_r <= `DELAY_RESET;
      halt_r                <= 2'b00;
      need_a_r              <= 6'h01;
      need_b_r              <= 6'h01;
    end else begin
      if (wr_pwr) begin
        pwr_bits_r <= wdata_r[6:0];
        startup_delay_count_r <= wdata_r[`POS_DELAY +: `DELAY_W];
      end
      if (wr_scan) begin
        halt_r   <= halt_now;
        need_a_r <= wdata_r[`POS_NEED_A +: 6];
        need_b_r <= wdata_r[`POS_NEED_B +: 6];
      end
    end
  end

  // ---------------------------------------------------------------
  // Scan activity and start-up delay
  // ---------------------------------------------------------------
  wire pd_cleared = wr_pwr &&
       ((conv_a_power_off && !wdata_r[`BIT_CONV_A_OFF]) ||
        (conv_b_power_off && !wdata_r[`BIT_CONV_B_OFF]));
  wire dly_tick = normal_mode || auto_standby_enable ? 1'b1 :
                  (stby_cfg ? stby_tick : 1'b1);
  wire dly_done = dly_run_r && dly_tick &&
                  dly_cnt_r >= startup_delay_count_r;
  wire core_res = core_data_valid && active && !dly_run_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      dly_run_r  <= 1'b0;
      dly_cnt_r  <= {`DELAY_W{1'b0}};
      psts_r     <= 2'b11;
      active_d_r <= 1'b0;
      scan_r     <= 2'b00;
      done_r     <= 2'b00;
      len_a_r    <= 2'h0;
      len_b_r    <= 2'h0;
    end else begin
      active_d_r <= active;
      if (pd_cleared || (!normal_mode && !active && |launch_req &&
          !dly_run_r && any_on && !(stby_cfg && !auto_powerdown_enable))) begin
        dly_run_r <= 1'b1;
        dly_cnt_r <= {`DELAY_W{1'b0}};
        psts_r    <= ~{!conv_b_power_off && (!auto_powerdown_enable ||
                       |need_b_r), !conv_a_power_off &&
                       (!auto_powerdown_enable || |need_a_r)} | 2'b11;
      end else if (dly_done) begin
        dly_run_r <= 1'b0;
        psts_r    <= {conv_b_power_off, conv_a_power_off};
      end else if (dly_run_r && dly_tick) begin
        dly_cnt_r <= dly_cnt_r + {{(`DELAY_W-1){1'b0}}, 1'b1};
      end else if (!dly_run_r) begin
        psts_r <= psts_r | {conv_b_power_off, conv_a_power_off};
      end
      if (launch_ok[0]) begin
        scan_r[0] <= 1'b1;
        len_a_r   <= 2'h0;
      end else if (halt_now[0] ||
                   (scan_r[0] && core_res && len_a_r == 2'h3)) begin
        scan_r[0] <= 1'b0;
        done_r[0] <= scan_r[0];
      end else if (scan_r[0] && core_res) begin
        len_a_r <= len_a_r + 2'h1;
      end
      if (launch_ok[1]) begin
        scan_r[1] <= 1'b1;
        len_b_r   <= 2'h0;
      end else if (halt_now[1] ||
                   (scan_r[1] && core_res && len_b_r == 2'h3)) begin
        scan_r[1] <= 1'b0;
        done_r[1] <= scan_r[1];
      end else if (scan_r[1] && core_res) begin
        len_b_r <= len_b_r + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Result path and analog controls
  // ---------------------------------------------------------------
  wire vref_on = !(vref_auto_power_off && !any_on) && clk_enable;
  wire cpu_res = wr_res && |halt_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      result_r         <= 16'h0000;
      result_valid     <= 1'b0;
      result_data      <= 16'h0000;
      result_from_cpu  <= 1'b0;
      adc_clk_en       <= 1'b0;
      adc_clk_sel_stby <= 1'b0;
      conv_a_power_en  <= 1'b0;
      conv_b_power_en  <= 1'b0;
      low_current_en   <= 1'b0;
      vref_power_en    <= 1'b0;
      vref_out_enable  <= 1'b0;
      pwm_data_en      <= 1'b0;
      scan_a_active    <= 1'b0;
      scan_b_active    <= 1'b0;
    end else begin
      result_valid    <= cpu_res || core_res;
      result_from_cpu <= cpu_res;
      if (cpu_res) begin
        result_r    <= wdata_r[15:0];
        result_data <= wdata_r[15:0];
      end else if (core_res) begin
        result_r    <= core_data;
        result_data <= core_data;
      end
      scan_a_active <= scan_r[0];
      scan_b_active <= scan_r[1];
      if (!any_on && !clk_enable) begin
        adc_clk_en       <= 1'b0;
        adc_clk_sel_stby <= 1'b0;
        low_current_en   <= 1'b0;
      end else if (normal_mode) begin
        adc_clk_en       <= 1'b1;
        adc_clk_sel_stby <= stby_cfg;
        low_current_en   <= stby_cfg;
      end else if (auto_powerdown_enable) begin
        adc_clk_en       <= active || dly_run_r;
        adc_clk_sel_stby <= stby_cfg;
        low_current_en   <= stby_cfg;
      end else if (auto_standby_enable) begin
        adc_clk_en       <= clk_enable;
        adc_clk_sel_stby <= !active && !dly_run_r;
        low_current_en   <= !active && !dly_run_r;
      end else begin
        adc_clk_en       <= clk_enable && any_on;
        adc_clk_sel_stby <= stby_cfg;
        low_current_en   <= stby_cfg;
      end
      conv_a_power_en <= !conv_a_power_off && clk_enable &&
          (!auto_powerdown_enable ||
           ((active || dly_run_r) && |need_a_r));
      conv_b_power_en <= !conv_b_power_off && clk_enable &&
          (!auto_powerdown_enable ||
           ((active || dly_run_r) && |need_b_r));
      vref_power_en   <= vref_on;
      vref_out_enable <= vref_on;
      pwm_data_en     <= vref_on;
    end
  end
endmodule

// file: design/adc_pwr_regs.vh
// Register map, field positions and timing constants of the power sequencer.
// Function
// - Normal mode: conversion clock always, no delay.
// - Auto power-down: gate clock, power down idle.
// - Auto power-down: start-up delay every scan.
// - Auto standby: standby clock and low current idle.
// - Auto standby: start-up delay every scan unless stby_cfg is set.
// - Standby mode: 100kHz clock, no scan delay.
// - Standby plus auto power-down: gate, delay.
// - Both off, clock disabled: everything shut down.
// - Reset powers down converters and reference.
// - Reference auto off when unused if set.
// - Reference down: outputs and PWM data low.
// - Delay on power-off clear and idle-to-active.
// - Auto power-down powers only required converters.
// - Scan starts ignored while status bit set.
// - Old results kept; new need fresh launch.
// - Halt bit stops scan, ignores launches.
// - Halted result writes processed like core data.
// - Standby clock is oscillator divided by eighty.
`ifndef ADC_PWR_REGS_VH
`define ADC_PWR_REGS_VH

`define OFS_POWER_CTRL   12'h000
`define OFS_SCAN_CTRL    12'h004
`define OFS_RESULT_WR    12'h008
`define OFS_RESULT_RD    12'h00C
`define OFS_ACTIVITY     12'h010

`define BIT_CONV_A_OFF   0
`define BIT_CONV_B_OFF   1
`define BIT_VREF_AUTO    2
`define BIT_APD          3
`define BIT_ASB          4
`define BIT_CLK_EN       5
`define BIT_STBY_CFG     6
`define BIT_PSTS_A       10
`define BIT_PSTS_B       11
`define POS_DELAY        16
`define DELAY_W          6

`define BIT_LAUNCH_A     0
`define BIT_LAUNCH_B     1
`define BIT_HALT_A       2
`define BIT_HALT_B       3
`define BIT_DONE_A       4
`define BIT_DONE_B       5
`define POS_NEED_A       8
`define POS_NEED_B       16

`define PWR_RESET        7'h07
`define DELAY_RESET      6'h0D
`define STBY_DIV         7'h50
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// file: design/standby_clk_div.v
// Divides the oscillator reference down to the standby clock enable.
`timescale 1ns/1ps
`include "adc_pwr_regs.vh"
module standby_clk_div #(
  parameter DIV = `STBY_DIV
) (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       osc_tick,
  output reg        stby_tick
);
  reg [6:0] cnt_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r     <= 7'h00;
      stby_tick <= 1'b0;
    end else begin
      stby_tick <= 1'b0;
      if (osc_tick) begin
        if (cnt_r == DIV - 7'h01) begin
          cnt_r     <= 7'h00;
          stby_tick <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 7'h01;
        end
      end
    end
  end
endmodule

// file: verif/adc_power_mode_sequencer_checker.sv
// Port-level assertions for the power-mode sequencer.
`timescale 1ns/1ps
`include "adc_pwr_regs.vh"
module adc_power_mode_sequencer_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        adc_clk_en,
  input wire        conv_a_power_en,
  input wire        conv_b_power_en,
  input wire        vref_power_en,
  input wire        vref_out_enable,
  input wire        pwm_data_en,
  input wire        scan_a_active,
  input wire        scan_b_active
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  chk_write_answer: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  chk_write_busy: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write ready while busy");
  chk_read_answer: assert property (rd_taken |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  chk_bad_read_zero: assert property (s_axi_rvalid &&
    s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  chk_ref_outputs: assert property (!vref_power_en |->
    !vref_out_enable && !pwm_data_en) else $error("reference outputs live");
  chk_scan_clock: assert property (scan_a_active || scan_b_active
    |-> adc_clk_en) else $error("scan without clock");
  chk_scan_power: assert property (scan_a_active |->
    conv_a_power_en) else $error("scan on unpowered converter");
  chk_ref_in_use: assert property (scan_a_active || scan_b_active
    |-> vref_power_en) else $error("reference off during scan");
  chk_reset_off: assert property (disable iff (1'b0) $rose(aresetn) |->
    !conv_a_power_en && !conv_b_power_en && !vref_power_en)
    else $error("powered after reset");
endmodule

// file: verif/adc_core_model.sv
// Behavioural analog cores and oscillator feeding the sequencer.
`timescale 1ns/1ps
module adc_core_model (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        adc_clk_en,
  input  wire        conv_a_power_en,
  input  wire        conv_b_power_en,
  input  wire        scan_a_active,
  input  wire        scan_b_active,
  output reg         osc_tick,
  output reg         core_data_valid,
  output reg  [15:0] core_data
);
  reg [3:0] osc_cnt;
  reg [2:0] smp_cnt;
  wire      busy = adc_clk_en && ((scan_a_active && conv_a_power_en) ||
                                  (scan_b_active && conv_b_power_en));
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt         <= 4'h0;
      osc_tick        <= 1'b0;
      smp_cnt         <= 3'h0;
      core_data_valid <= 1'b0;
      core_data       <= 16'hA5A0;
    end else begin
      osc_cnt  <= (osc_cnt == 4'hB) ? 4'h0 : osc_cnt + 4'h1;
      osc_tick <= (osc_cnt == 4'hB);
      smp_cnt  <= smp_cnt + 3'h1;
      core_data_valid <= busy && (smp_cnt == 3'h7);
      // Between samples the data bus wanders so stale values never match.
      core_data <= (busy && smp_cnt == 3'h7) ? core_data + 16'h0008
                                              : ~core_data;
    end
  end
endmodule

// file: verif/test_adc_power_mode_sequencer.sv
// Register-level test of the power-mode sequencer.
`timescale 1ns/1ps
`include "adc_pwr_regs.vh"
module test_adc_power_mode_sequencer;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg         sync_a, sync_b;
  reg  [11:0] awaddr, araddr;
  reg  [31:0] wdata, d;
  reg  [3:0]  wstrb;
  reg  [1:0]  r;
  wire        awready, wready, bvalid, arready, rvalid, osc_tick, dvalid;
  wire        clk_en, clk_stby, pa, pb, low_cur, vref_pw, vref_out, pwm_en;
  wire        act_a, act_b, res_valid, res_cpu;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] cdata, res_data;
  wire [3:0]  mon = {act_b, act_a, pb, pa};
  integer     failures, checks_done, k;
  reg         cpu_seen = 1'b0;

  adc_power_mode_sequencer i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .osc_tick(osc_tick),
    .conv_sync_a(sync_a), .conv_sync_b(sync_b), .core_data_valid(dvalid),
    .core_data(cdata), .adc_clk_en(clk_en), .adc_clk_sel_stby(clk_stby),
    .conv_a_power_en(pa), .conv_b_power_en(pb), .low_current_en(low_cur),
    .vref_power_en(vref_pw), .vref_out_enable(vref_out),
    .pwm_data_en(pwm_en), .scan_a_active(act_a), .scan_b_active(act_b),
    .result_valid(res_valid), .result_data(res_data),
    .result_from_cpu(res_cpu));

  adc_core_model i_core (.aclk(aclk), .aresetn(aresetn), .adc_clk_en(clk_en),
    .conv_a_power_en(pa), .conv_b_power_en(pb), .scan_a_active(act_a),
    .scan_b_active(act_b), .osc_tick(osc_tick), .core_data_valid(dvalid),
    .core_data(cdata));

  initial aclk = 1'b0;
  always #5 aclk = ~aclk;
  // Result pulses last one cycle, so they are caught here and checked later.
  always @(posedge aclk) cpu_seen <= cpu_seen | (res_valid & res_cpu);

  task check(input [31:0] seen, input [31:0] exp, input string name);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task complete_run;
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Each bus task starts one edge later so a release and a new request
  // never land on the same signal in one time step.
  task wr(input [11:0] a, input [31:0] v);
    integer n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (n < 40) begin
      @(posedge aclk);
      n = n + 1;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        n = 99;
      end
    end
    if (n != 99) begin
      failures = failures + 1;
      complete_run;
    end
  endtask

  task rd(input [11:0] a);
    integer n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (n < 40) begin
      @(posedge aclk);
      n = n + 1;
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        n = 99;
      end
    end
    if (n != 99) begin
      failures = failures + 1;
      complete_run;
    end
  endtask

  task wt(input integer i, input logic v);
    integer n;
    n = 0;
    while (n < 400) begin
      @(posedge aclk);
      n = (mon[i] === v) ? 999 : n + 1;
    end
    if (n != 999) begin
      failures = failures + 1;
      complete_run;
    end
  endtask

  initial begin
    failures = 0; checks_done = 0; aresetn = 1'b0; awvalid = 1'b0;
    wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0; wstrb = 4'hF;
    sync_a = 1'b0; sync_b = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({vref_pw, pa, pb}, 32'h0, "reset_power");
    rd(`OFS_POWER_CTRL);
    check(d & 32'h003F_007F, 32'h000D_0007, "power_reg");
    rd(`OFS_ACTIVITY);
    check(d, 32'h0000_0003, "activity");
    rd(12'h020);
    check({r, d[29:0]}, {`RESP_SLVERR, 30'h0}, "bad_read");
    wr(12'h020, 32'hFFFF_FFFF);
    check(r, `RESP_SLVERR, "bad_write");
    wr(`OFS_POWER_CTRL, 32'h003F_0026);
    wr(`OFS_SCAN_CTRL, 32'h0000_0101);
    check(act_a, 0, "launch_in_delay");
    k = 0;
    d = 32'h1;
    while (d[0] !== 1'b0 && k < 40) begin
      rd(`OFS_ACTIVITY);
      k = k + 1;
    end
    check(d[0], 0, "status_a_clear");
    check({clk_en, pa, pb, vref_pw}, 4'hD, "normal_on");
    wr(`OFS_SCAN_CTRL, 32'h0000_0101);
    wt(2, 1'b1);
    wt(2, 1'b0);
    check(clk_en, 1, "normal_idle_clk");
    wr(`OFS_SCAN_CTRL, 32'h0000_0105);
    sync_a <= 1'b1;
    repeat (10) @(posedge aclk);
    check(act_a, 0, "halted");
    sync_a <= 1'b0;
    wr(`OFS_RESULT_WR, 32'h0000_1238);
    rd(`OFS_RESULT_RD);
    check(d[15:0], 16'h1238, "cpu_result");
    check({cpu_seen, res_data}, 32'h0001_1238, "cpu_result_out");
    wr(`OFS_SCAN_CTRL, 32'h0);
    sync_a <= 1'b1;
    wt(2, 1'b1);
    sync_a <= 1'b0;
    wt(2, 1'b0);
    wr(`OFS_POWER_CTRL, 32'h0005_0023);
    repeat (4) @(posedge aclk);
    check(vref_pw, 1, "vref_manual");
    wr(`OFS_POWER_CTRL, 32'h0005_0007);
    repeat (4) @(posedge aclk);
    check({clk_en,vref_pw,vref_out,pwm_en}, 0, "full_off");
    wr(`OFS_POWER_CTRL, 32'h0008_002C);
    repeat (20) @(posedge aclk);
    check({clk_en, pa, pb}, 0, "apd_idle");
    wr(`OFS_SCAN_CTRL, 32'h0000_0101);
    wt(0, 1'b1);
    check(pb, 0, "apd_only_a");
    wt(2, 1'b1);
    wt(2, 1'b0);
    repeat (4) @(posedge aclk);
    check({clk_en, pa}, 0, "apd_after");
    wr(`OFS_POWER_CTRL, 32'h0005_0007);
    wr(`OFS_POWER_CTRL, 32'h0005_0024);
    repeat (20) @(posedge aclk);
    wr(`OFS_POWER_CTRL, 32'h0003_0034);
    repeat (20) @(posedge aclk);
    check({clk_stby, low_cur}, 2'h3, "asb_idle");
    wr(`OFS_SCAN_CTRL, 32'h0000_0101);
    wt(2, 1'b1);
    check({clk_stby, low_cur}, 0, "asb_active");
    wt(2, 1'b0);
    wr(`OFS_POWER_CTRL, 32'h0005_0007);
    wr(`OFS_POWER_CTRL, 32'h0001_006E);
    repeat (4) @(posedge aclk);
    check({clk_en, clk_stby, low_cur, pa}, 4'hF, "hybrid_delay");
    repeat (2000) @(posedge aclk);
    check({clk_en, pa}, 0, "hybrid_idle");
    wr(`OFS_POWER_CTRL, 32'h0000_0066);
    wr(`OFS_SCAN_CTRL, 32'h0000_0101);
    wt(2, 1'b1);
    check({clk_en, clk_stby, low_cur}, 3'h7, "stby_scan");
    wt(2, 1'b0);
    complete_run;
  end
endmodule

bind adc_power_mode_sequencer adc_power_mode_sequencer_checker i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .adc_clk_en(adc_clk_en),
  .conv_a_power_en(conv_a_power_en), .conv_b_power_en(conv_b_power_en),
  .vref_power_en(vref_power_en), .vref_out_enable(vref_out_enable),
  .pwm_data_en(pwm_data_en), .scan_a_active(scan_a_active),
  .scan_b_active(scan_b_active));
